// ### rtl/nand_port_defines.svh
// Constants for the NAND bus port controller
// Operation
// - Eight shared lines carry command, address, data
// - Command latched on write strobe rise, CLE
// - Address latched on write strobe rise, ALE
// - Data latched on write strobe rise otherwise
// - Read strobe cycle no faster than 42 ns
// - Operations chosen by documented command codes
// - Four address cycles; erase uses three rows
`ifndef NAND_PORT_DEFINES_SVH
`define NAND_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_READ_A 8'h00
`define CMD_READ_B 8'h01
`define CMD_READ_SPARE 8'h50
`define CMD_READ_ID 8'h90
`define CMD_RESET 8'hFF
`define CMD_PROG 8'h80
`define CMD_PROG_GO 8'h10
`define CMD_ERASE 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_STATUS 8'h70

// ----------------------------------------------------------------
// Timing, 100 MHz clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define READ_CYCLE_NS 42
`define READ_CYCLE_CYC ((`READ_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_LOW_CYC 2
`define PAGE_BYTES 528
`define BUSY_WAIT_CYC 4
`define BUSY_TIMEOUT_US 4000
`define BUSY_TIMEOUT_CYC (`BUSY_TIMEOUT_US * 1000 / `CLK_PERIOD_NS)

`endif

// ### rtl/nand_port_host.sv
// Controller that drives a byte-wide NAND flash through its pins
`include "nand_port_defines.svh"

module nand_port_host #(
    parameter int BYTE_CAP = `PAGE_BYTES,
    parameter int TIMEOUT_CYC = `BUSY_TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input wire nand_port_pkg::req_t req,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    output logic done,
    output logic timeout,
    input wire logic write_enable,
    output nand_port_pkg::pins_t pins,
    input wire logic [7:0] shared_bus_lines_i,
    input wire logic ready_busy_i
);

    // Counts beyond the field widths would wrap silently
    if (BYTE_CAP < 1 || BYTE_CAP > 1023 ||
        TIMEOUT_CYC < 16 || TIMEOUT_CYC > 16777215) begin : g_bad_params
        $error("nand_port_host: unsupported parameters");
    end

    localparam logic [4:0] RCYC = 5'(`READ_CYCLE_CYC);
    localparam logic [4:0] LOWC = 5'(`STROBE_LOW_CYC);
    // First tick of the low phase at which a read byte may be taken
    localparam logic [4:0] SAMPLE_TICK = RCYC - LOWC - 5'h01;

    // ----------------------------------------------------------------
    // State record
    // ----------------------------------------------------------------
    typedef struct packed {
        nand_port_pkg::state_t st;
        nand_port_pkg::req_t r;
        nand_port_pkg::pins_t p;
        logic [2:0] acnt;
        logic [9:0] bcnt;
        logic [4:0] tick;
        logic [23:0] wait_cnt;
        logic [2:0] rb_sync;
        logic rb_q;
        logic [7:0] bus_sync1;
        logic [7:0] bus_sync2;
        logic [7:0] bus_sync3;
        logic [7:0] buf0;
        logic [7:0] buf1;
        logic [1:0] fill;
        logic done;
        logic timeout;
    } core_t;

    core_t s_q, s_d;

    // First command byte of each operation
    function automatic logic [7:0] first_cmd(input nand_port_pkg::req_t r);
        case (r.op)
            nand_port_pkg::OP_READ: first_cmd = r.spare ? `CMD_READ_SPARE :
                (r.half_b ? `CMD_READ_B : `CMD_READ_A);
            nand_port_pkg::OP_PROGRAM: first_cmd = `CMD_PROG;
            nand_port_pkg::OP_ERASE: first_cmd = `CMD_ERASE;
            nand_port_pkg::OP_STATUS: first_cmd = `CMD_STATUS;
            nand_port_pkg::OP_READ_ID: first_cmd = `CMD_READ_ID;
            default: first_cmd = `CMD_RESET;
        endcase
    endfunction

    // Number of address cycles; erase skips the column
    function automatic logic [2:0] addr_cycles(input nand_port_pkg::op_t op);
        case (op)
            nand_port_pkg::OP_READ, nand_port_pkg::OP_PROGRAM: addr_cycles = 3'h4;
            nand_port_pkg::OP_ERASE: addr_cycles = 3'h3;
            nand_port_pkg::OP_READ_ID: addr_cycles = 3'h1;
            default: addr_cycles = 3'h0;
        endcase
    endfunction

    // Address byte for cycle index, column first then three rows
    function automatic logic [7:0] addr_byte(input nand_port_pkg::req_t r, input logic [2:0] i);
        logic [2:0] k;
        k = (r.op == nand_port_pkg::OP_ERASE) ? 3'(i + 3'h1) : i;
        case (k)
            3'h0: addr_byte = (r.op == nand_port_pkg::OP_READ_ID) ? 8'h00 : r.column;
            3'h1: addr_byte = r.row[7:0];
            3'h2: addr_byte = r.row[15:8];
            default: addr_byte = {7'h00, r.row[16]};
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic strobe_end, pop;
        strobe_end = (s_q.tick == 5'h00);
        pop = rd_valid && rd_ready;
        s_d = s_q;
        s_d.done = 1'b0;
        // Ready/busy through three flops, change once last two agree
        s_d.rb_sync = {s_q.rb_sync[1:0], ready_busy_i};
        if (s_q.rb_sync[2] == s_q.rb_sync[1]) begin
            s_d.rb_q = s_q.rb_sync[2];
        end
        s_d.bus_sync1 = shared_bus_lines_i;
        s_d.bus_sync2 = s_q.bus_sync1;
        s_d.bus_sync3 = s_q.bus_sync2;
        if (s_q.tick != 5'h00) begin
            s_d.tick = s_q.tick - 5'h01;
        end
        // Buffer drain: shift the older word out
        if (pop) begin
            s_d.buf0 = s_q.buf1;
            s_d.fill = s_q.fill - 2'h1;
        end
        s_d.p.wp_n = write_enable;
        case (s_q.st)
            nand_port_pkg::ST_IDLE: begin
                s_d.p.ce_n = 1'b1;
                s_d.p.bus_oe = 1'b0;
                if (req_valid) begin
                    s_d.r = req;
                    s_d.timeout = 1'b0;
                    s_d.p.ce_n = 1'b0;
                    s_d.p.cle = 1'b1;
                    s_d.p.we_n = 1'b0;
                    s_d.p.bus_o = first_cmd(req);
                    s_d.p.bus_oe = 1'b1;
                    s_d.tick = LOWC;
                    s_d.acnt = 3'h0;
                    s_d.bcnt = 10'h000;
                    s_d.st = nand_port_pkg::ST_CMD;
                end
            end
            nand_port_pkg::ST_CMD, nand_port_pkg::ST_ADDR, nand_port_pkg::ST_CMD2: begin
                if (strobe_end && !s_q.p.we_n) begin
                    s_d.p.we_n = 1'b1; // Rising edge latches the byte
                    s_d.tick = LOWC;
                end else if (strobe_end) begin
                    s_d.p.cle = 1'b0;
                    s_d.p.ale = 1'b0;
                    if (s_q.st == nand_port_pkg::ST_CMD2 ||
                        (s_q.st == nand_port_pkg::ST_CMD && s_q.r.op == nand_port_pkg::OP_RESET)) begin
                        s_d.p.bus_oe = 1'b0;
                        s_d.wait_cnt = 24'(`BUSY_WAIT_CYC);
                        s_d.st = nand_port_pkg::ST_WAIT;
                    end else if (s_q.acnt < addr_cycles(s_q.r.op)) begin
                        s_d.p.ale = 1'b1;
                        s_d.p.we_n = 1'b0;
                        s_d.p.bus_o = addr_byte(s_q.r, s_q.acnt);
                        s_d.acnt = s_q.acnt + 3'h1;
                        s_d.tick = LOWC;
                        s_d.st = nand_port_pkg::ST_ADDR;
                    end else if (s_q.r.op == nand_port_pkg::OP_ERASE) begin
                        s_d.p.cle = 1'b1;
                        s_d.p.we_n = 1'b0;
                        s_d.p.bus_o = `CMD_ERASE_GO;
                        s_d.tick = LOWC;
                        s_d.st = nand_port_pkg::ST_CMD2;
                    end else if (s_q.r.op == nand_port_pkg::OP_PROGRAM) begin
                        s_d.st = nand_port_pkg::ST_WDATA;
                    end else if (s_q.r.op == nand_port_pkg::OP_READ) begin
                        s_d.p.bus_oe = 1'b0;
                        s_d.wait_cnt = 24'(`BUSY_WAIT_CYC);
                        s_d.st = nand_port_pkg::ST_WAIT; // Page fetch
                    end else begin
                        s_d.p.bus_oe = 1'b0;
                        s_d.st = nand_port_pkg::ST_RDATA;
                    end
                end
            end
            nand_port_pkg::ST_WDATA: begin
                if (strobe_end && !s_q.p.we_n) begin
                    s_d.p.we_n = 1'b1;
                    s_d.tick = LOWC;
                    s_d.bcnt = s_q.bcnt + 10'h001;
                end else if (strobe_end && s_q.bcnt == s_q.r.count) begin
                    s_d.p.cle = 1'b1;
                    s_d.p.we_n = 1'b0;
                    s_d.p.bus_o = `CMD_PROG_GO;
                    s_d.tick = LOWC;
                    s_d.st = nand_port_pkg::ST_CMD2;
                end else if (strobe_end && wr_valid) begin
                    s_d.p.we_n = 1'b0;
                    s_d.p.bus_o = wr_data;
                    s_d.tick = LOWC;
                end
            end
            nand_port_pkg::ST_WAIT: begin
                // Device runs the operation alone; chip stays selected
                s_d.wait_cnt = s_q.wait_cnt + 24'h000001;
                if (s_q.wait_cnt[23:3] == 21'h0) begin
                    s_d.wait_cnt = (s_q.wait_cnt == 24'h0) ? 24'h8 : s_q.wait_cnt - 24'h1;
                end else if (s_q.rb_q) begin
                    // Ready again, next command allowed
                    s_d.st = (s_q.r.op == nand_port_pkg::OP_READ) ?
                        nand_port_pkg::ST_RDATA : nand_port_pkg::ST_DONE;
                end else if (s_q.wait_cnt >= 24'(TIMEOUT_CYC)) begin
                    s_d.timeout = 1'b1;
                    s_d.st = nand_port_pkg::ST_DONE;
                end
            end
            nand_port_pkg::ST_RDATA: begin
                if (!s_q.p.output_strobe_n && s_q.tick <= SAMPLE_TICK &&
                    s_q.bus_sync2 == s_q.bus_sync3) begin
                    // Byte counts once the last two bus flops agree
                    s_d.p.output_strobe_n = 1'b1;
                    if (pop) begin
                        // One word leaves as one arrives, so fill is unchanged
                        s_d.fill = s_q.fill;
                        if (s_q.fill == 2'h1) s_d.buf0 = s_q.bus_sync3;
                        else s_d.buf1 = s_q.bus_sync3;
                    end else begin
                        if (s_q.fill == 2'h0) s_d.buf0 = s_q.bus_sync3;
                        else s_d.buf1 = s_q.bus_sync3;
                        s_d.fill = s_q.fill + 2'h1;
                    end
                    s_d.bcnt = s_q.bcnt + 10'h001;
                end else if (strobe_end && s_q.p.output_strobe_n) begin
                    if (s_q.bcnt == s_q.r.count) begin
                        s_d.st = nand_port_pkg::ST_DONE;
                    end else if (s_d.fill != 2'h2) begin
                        // Stall by reader holds strobe high; no byte lost
                        s_d.p.output_strobe_n = 1'b0;
                        s_d.tick = RCYC;
                    end
                end
            end
            nand_port_pkg::ST_DONE: begin
                if (s_q.fill == 2'h0) begin
                    s_d.done = 1'b1;
                    s_d.p.ce_n = 1'b1;
                    s_d.st = nand_port_pkg::ST_IDLE;
                end
            end
            default: s_d.st = nand_port_pkg::ST_IDLE;
        endcase
        if (!resetn) begin
            s_d = '0;
            s_d.st = nand_port_pkg::ST_IDLE;
            s_d.p.ce_n = 1'b1;
            s_d.p.we_n = 1'b1;
            s_d.p.output_strobe_n = 1'b1;
            s_d.rb_sync = 3'h7;
            s_d.rb_q = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign req_ready = (s_q.st == nand_port_pkg::ST_IDLE);
    assign wr_ready = (s_q.st == nand_port_pkg::ST_WDATA) && (s_q.tick == 5'h00) &&
        s_q.p.we_n && (s_q.bcnt != s_q.r.count);
    assign rd_valid = (s_q.fill != 2'h0);
    assign rd_data = s_q.buf0;
    assign done = s_q.done;
    assign timeout = s_q.timeout;
    assign pins = s_q.p;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence read_pulse;
        !pins.output_strobe_n ##1 !pins.output_strobe_n;
    endsequence

    a_no_bus_clash: assert property (@(posedge ref_clk) disable iff (!resetn)
        !pins.output_strobe_n |-> !pins.bus_oe) else $error("bus driven during read");
    a_read_cycle_time: assert property (@(posedge ref_clk) disable iff (!resetn)
        $fell(pins.output_strobe_n) |-> read_pulse ##1 !pins.output_strobe_n)
        else $error("read strobe too short");
    a_latch_exclusive: assert property (@(posedge ref_clk) disable iff (!resetn)
        !(pins.cle && pins.ale)) else $error("both latch strobes high");
    a_cmd_driven: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(pins.we_n) |-> pins.bus_oe && !pins.ce_n) else $error("write edge undriven");
    a_wp_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(resetn) |-> pins.wp_n == $past(write_enable)) else $error("lock pin wrong");
    a_wait_selected: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.st == nand_port_pkg::ST_WAIT |-> !pins.ce_n) else $error("deselected busy");
    a_erase_go: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.st == nand_port_pkg::ST_CMD2 && s_q.r.op == nand_port_pkg::OP_ERASE
        |-> pins.bus_o == `CMD_ERASE_GO) else $error("wrong erase confirm");
    a_no_strobe_busy: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.st == nand_port_pkg::ST_WAIT |-> pins.we_n && pins.output_strobe_n)
        else $error("strobe while busy");

endmodule

// ### rtl/nand_port_pkg.sv
// Types for the NAND bus port controller
package nand_port_pkg;

    // Operations requested by the user side
    typedef enum logic [2:0] {
        OP_READ,
        OP_PROGRAM,
        OP_ERASE,
        OP_STATUS,
        OP_RESET,
        OP_READ_ID
    } op_t;

    // One user request
    typedef struct packed {
        op_t op;
        logic spare;
        logic half_b;
        logic [7:0] column;
        logic [16:0] row;
        logic [9:0] count;
    } req_t;

    // Pins driven toward the flash
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic output_strobe_n;
        logic wp_n;
        logic [7:0] bus_o;
        logic bus_oe;
    } pins_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_WDATA,
        ST_CMD2,
        ST_WAIT,
        ST_RDATA,
        ST_DONE
    } state_t;

endpackage

// ### test/nand_dev_model.sv
// Behavioural model of the flash device as seen at the host pins
module nand_dev_model #(
    parameter int output_valid_delay = 5
) (
    input wire nand_port_pkg::pins_t pins,
    input wire logic [7:0] bus,
    input wire logic [15:0] busy_ns,
    output logic [7:0] dev_o,
    output logic rb_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cmd_first, col;
    logic [7:0] adr [0:3];
    logic [7:0] wdat [0:15];
    int n_cmd, n_addr, n_data, n_busy, n_fast, n_early;
    logic prog_locked;
    realtime t_fall, t_busy;
    initial begin
        t_busy = 0.0;
        dev_o = 8'h5A;
        rb_low = 1'h0;
        n_fast = 0;
        n_early = 0;
        t_fall = -1000.0;
    end
    // ----------------------------------------
    // Busy window, blind to chip select
    // ----------------------------------------
    task automatic go_busy();
        n_busy++;
        t_busy = $realtime;
        rb_low = 1'h1;
        #(busy_ns);
        rb_low = 1'h0;
    endtask
    // Commands while busy other than reset or status are host slips;
    // the edge that opens a busy window is not one of them
    always @(posedge pins.we_n) begin
        if (rb_low && $realtime > t_busy && !pins.ce_n && pins.cle &&
            bus != 8'hFF && bus != 8'h70) n_early++;
    end
    // Latch on write strobe rise; the wire is sampled, not the host's copy
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.cle) begin
            if (bus != 8'h10 && bus != 8'hD0) begin
                cmd_first = bus;
                n_cmd = 0;
                n_addr = 0;
                n_data = 0;
                n_busy = 0;
                prog_locked = 1'h0;
                col = 8'h00;
            end
            n_cmd++;
            if (bus == 8'h10 && !pins.wp_n) prog_locked = 1'h1;
            else if (bus inside {8'h10, 8'hD0, 8'hFF}) go_busy();
        end else if (!pins.ce_n && pins.ale) begin
            if (n_addr < 4) adr[n_addr] = bus;
            if (n_addr == 0) col = bus;
            n_addr++;
            if (n_addr == 4 && cmd_first inside {8'h00, 8'h01, 8'h50}) go_busy();
        end else if (!pins.ce_n) begin
            if (n_data < 16) wdat[n_data] = bus;
            n_data++;
        end
    end
    // Read byte appears late after the fall, and the column moves on
    always @(negedge pins.output_strobe_n) begin
        if (!pins.ce_n) begin
            if ($realtime - t_fall < 42.0) n_fast++;
            t_fall = $realtime;
            dev_o <= #(output_valid_delay) col;
            col = col + 8'h01;
        end
    end
    // Released bus shows the inverse so a stale byte cannot pass
    always @(posedge pins.output_strobe_n) dev_o <= ~dev_o;
endmodule

// ### test/tb_nand_port_host.sv
// Self-checking bench for the NAND host port controller
module tb_nand_port_host;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        nand_port_pkg::op_t op;
        logic spare, half_b;
        logic [9:0] cnt;
        logic [7:0] cmd;
        int ncmd, naddr, nbusy;
    } row_t;
    logic ref_clk = 1'h0, resetn, req_valid, req_ready, wr_valid, wr_ready, rd_valid, rd_ready;
    logic done, timeout, write_enable, rb_low;
    logic [7:0] wr_data, rd_data, dev_o;
    logic [15:0] busy_ns;
    nand_port_pkg::req_t req;
    nand_port_pkg::pins_t pins;
    wire logic [7:0] bus = pins.bus_oe ? pins.bus_o : dev_o;
    int failures = 0, checks = 0;
    logic [7:0] rdq [$];
    logic [7:0] ea [0:3];
    row_t rows [8] = '{
        '{nand_port_pkg::OP_READ, 1'h0, 1'h0, 10'h004, 8'h00, 1, 4, 1},
        '{nand_port_pkg::OP_READ, 1'h0, 1'h1, 10'h003, 8'h01, 1, 4, 1},
        '{nand_port_pkg::OP_READ, 1'h1, 1'h0, 10'h002, 8'h50, 1, 4, 1},
        '{nand_port_pkg::OP_PROGRAM, 1'h0, 1'h0, 10'h003, 8'h80, 2, 4, 1},
        '{nand_port_pkg::OP_ERASE, 1'h0, 1'h0, 10'h000, 8'h60, 2, 3, 1},
        '{nand_port_pkg::OP_STATUS, 1'h0, 1'h0, 10'h001, 8'h70, 1, 0, 0},
        '{nand_port_pkg::OP_RESET, 1'h0, 1'h0, 10'h000, 8'hFF, 1, 0, 1},
        '{nand_port_pkg::OP_READ_ID, 1'h0, 1'h0, 10'h002, 8'h90, 1, 1, 0}};
    always #5 ref_clk = ~ref_clk;
    nand_port_host #(.TIMEOUT_CYC(200)) uut (.ref_clk(ref_clk), .resetn(resetn),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .done(done), .timeout(timeout), .write_enable(write_enable),
        .pins(pins), .shared_bus_lines_i(bus), .ready_busy_i(~rb_low));
    nand_dev_model dev (.pins(pins), .bus(bus), .busy_ns(busy_ns), .dev_o(dev_o),
        .rb_low(rb_low));
    // Byte streams on both user sides
    always @(posedge ref_clk) begin
        if (wr_valid === 1'h1 && wr_ready === 1'h1) wr_data <= wr_data + 8'h01;
        if (rd_valid === 1'h1 && rd_ready === 1'h1) rdq.push_back(rd_data);
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One request, held until taken, then a bounded wait for its end
    task automatic run(input nand_port_pkg::op_t op, input logic sp, hb, input logic [9:0] cnt);
        int n;
        rdq.delete();
        @(posedge ref_clk);
        wr_data <= 8'h30;
        req <= '{op, sp, hb, 8'h12, 17'h1ABCD, cnt};
        req_valid <= 1'h1;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (req_ready !== 1'h1 && n < 50);
        req_valid <= 1'h0;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (done !== 1'h1 && timeout !== 1'h1 && n < 20000);
        if (n >= 20000) check("done", 1, 0);
        repeat (20) @(posedge ref_clk);
    endtask
    // Read bytes count up from the start column
    task automatic check_rd(input int cnt, input logic [7:0] base);
        check("rd_count", cnt, rdq.size());
        for (int k = 0; k < cnt && k < rdq.size(); k++) check("rd_data", base + k, rdq[k]);
    endtask
    initial begin
        #400us;
        check("watchdog", 0, 1);
        close_out();
    end
    initial begin
        resetn = 1'h0;
        req_valid = 1'h0;
        req = '0;
        wr_valid = 1'h1;
        wr_data = 8'h30;
        rd_ready = 1'h1;
        write_enable = 1'h1;
        busy_ns = 16'h012C;
        repeat (5) @(posedge ref_clk);
        #1;
        check("reset pins", 8'h90, {pins.ce_n, pins.cle, pins.ale, pins.we_n, 3'h0, pins.bus_oe});
        check("reset strobe", 1, pins.output_strobe_n);
        @(posedge ref_clk) resetn <= 1'h1;
        // Table of ordinary operations, one per command code
        for (int i = 0; i < 8; i++) begin
            run(rows[i].op, rows[i].spare, rows[i].half_b, rows[i].cnt);
            if (rows[i].naddr == 4) ea = '{8'h12, 8'hCD, 8'hAB, 8'h01};
            else if (rows[i].naddr == 3) ea = '{8'hCD, 8'hAB, 8'h01, 8'h00};
            else ea = '{4{8'h00}};
            check("cmd", rows[i].cmd, dev.cmd_first);
            check("cmd_cycles", rows[i].ncmd, dev.n_cmd);
            check("addr_cycles", rows[i].naddr, dev.n_addr);
            for (int k = 0; k < rows[i].naddr; k++) check("addr", ea[k], dev.adr[k]);
            check("busy_runs", rows[i].nbusy, dev.n_busy);
            check("no_timeout", 0, timeout);
            if (rows[i].op == nand_port_pkg::OP_PROGRAM) begin
                check("wr_count", rows[i].cnt, dev.n_data);
                for (int k = 0; k < 3; k++) check("wr_byte", 8'h30 + k, dev.wdat[k]);
            end else if (rows[i].cnt != 0) begin
                check_rd(rows[i].cnt, rows[i].op == nand_port_pkg::OP_READ ? 8'h12 : 8'h00);
            end
            $display("test %0d finished", i);
        end
        // Locked program must not start a busy period in the device
        @(posedge ref_clk) write_enable <= 1'h0;
        repeat (3) @(posedge ref_clk);
        check("wp_n", 0, pins.wp_n);
        run(nand_port_pkg::OP_PROGRAM, 1'h0, 1'h0, 10'h002);
        check("locked", 1, dev.prog_locked);
        check("locked_busy", 0, dev.n_busy);
        @(posedge ref_clk) write_enable <= 1'h1;
        $display("test lock finished");
        // Receiver stalls: the strobe waits and no byte is lost
        @(posedge ref_clk) rd_ready <= 1'h0;
        fork
            run(nand_port_pkg::OP_READ, 1'h0, 1'h0, 10'h008);
            begin
                repeat (300) @(posedge ref_clk);
                check("stalled_pops", 0, rdq.size());
                rd_ready <= 1'h1;
            end
        join
        check_rd(8, 8'h12);
        check("fast_strobes", 0, dev.n_fast);
        check("early_cmds", 0, dev.n_early);
        $display("test stall finished");
        // Device that never comes ready within the limit
        @(posedge ref_clk) busy_ns <= 16'h0BB8;
        run(nand_port_pkg::OP_ERASE, 1'h0, 1'h0, 10'h000);
        check("timeout", 1, timeout);
        #4us;
        $display("test timeout finished");
        close_out();
    end
endmodule
